// >>> rtl/otsp_core.sv
// thermistor scan, over-temperature protection and register slave
//
// How it works
// RULE_01 - default periodic scan powers thermistor 5 ms each 640 ms
// RULE_02 - every supply turn-on waits 1 ms settling before comparing
// RULE_03 - after settling, input below supply/13 means external fail
// RULE_04 - external-temp select keeps supply on, routes thermistor to analog output
// RULE_05 - manual select enables detection only 1 ms after supply turns on
// RULE_06 - scan-disable stops periodic scan; otherwise scan and manual coexist
// RULE_07 - force bit holds supply on continuously, overriding both scans
// RULE_08 - over-temperature turns both switches off and sets matching flag
// RULE_09 - switches stay off until temperature recovers
// RULE_10 - switch-control writes ignored during shutdown; monitoring stays available
// RULE_11 - internal response disable stops automatic shutdown on internal heat
// RULE_12 - external response disable stops automatic shutdown on external heat
// RULE_13 - microcontroller writes four-bit analog select field
// RULE_14 - any overcurrent or short-circuit flag also turns supply on
// RULE_15 - scan timing from free-running counter; comparator synchronised first
// RULE_16 - comparator sampled only when settled; last result held otherwise
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module otsp_core
   import otsp_pkg::*;
#(
   parameter int PERIOD_CYC = SCAN_PERIOD_CYC, // scan period in cycles
   parameter int ON_CYC = SCAN_ON_CYC, // scan on-time in cycles
   parameter int SETTLE = SETTLE_CYC // settling delay in cycles
) (
   input wire logic core_clk, // 50 MHz clock
   input wire logic srst, // synchronous reset, active high
   input wire logic [3:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input wire logic extBelowPin, // thermistor below reference, async
   input wire logic intHotPin, // internal over-temp, async
   input wire logic chargeOvercurrentFlag, // overcurrent flag
   input wire logic dischargeOvercurrentFlag, // overcurrent flag
   input wire logic shortCircuitFlag, // short-circuit flag
   output logic thermistorSupplyOut, // thermistor divider supply
   output logic thermistorToAnalog, // route thermistor input to analog output
   output logic [3:0] analogSelectField, // mux select to analog path
   output logic chargeSwitchCtrl, // charge switch drive
   output logic dischargeSwitchCtrl, // discharge switch drive
   output logic irq // level interrupt
);
   localparam int PW = $clog2(PERIOD_CYC + 1);
   localparam int SW = $clog2(SETTLE + 1);

   otsp_sync_if syncBus ();
   otsp_pin_sync uSync (
      .core_clk(core_clk),
      .srst(srst),
      .extBelowPin(extBelowPin),
      .intHotPin(intHotPin),
      .syncOut(syncBus)
   );

   logic [31:0] ctrl_q;
   logic [ST_W-1:0] status_q;
   logic [ST_W-1:0] mask_q;
   logic [PW-1:0] scanCnt_q;
   logic [SW-1:0] settleCnt_q;
   otsp_sup_t supSt_q;
   otsp_sup_t supSt_d;
   logic extFail_q;
   logic shutdown_q;
   logic ack_q;
   logic waitReq_q;
   logic [31:0] rdata_q;
   logic supply_q;
   logic route_q;
   logic chg_q;
   logic dsg_q;
   logic irq_q;

   // register decode
   // request taken while idle; a write lands only at the edge after the taking edge, ending the cycle with the stall low
   wire busReq = (avs_read | avs_write) & ~ack_q;
   wire busDone = avs_write & ack_q;
   wire selCtrl = (avs_address == REG_CTRL);
   wire selStat = (avs_address == REG_STATUS);
   wire selMask = (avs_address == REG_MASK);
   wire selState = (avs_address == REG_STATE);
   wire wrCtrl = busDone & selCtrl;
   wire wrStat = busDone & selStat;
   wire wrMask = busDone & selMask;
   wire [31:0] beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   wire scanOff = ctrl_q[CTRL_SCAN_OFF];
   wire forceOn = ctrl_q[CTRL_FORCE];
   wire disInt = ctrl_q[CTRL_DIS_INT];
   wire disExt = ctrl_q[CTRL_DIS_EXT];
   wire [3:0] sel = ctrl_q[CTRL_SEL_LO +: 4];
   wire manualSel = (sel == AMUX_EXT_TEMP); // RULE_04 RULE_13

   // free-running period counter keeps phase even while the scan is disabled
   wire periodEnd = (scanCnt_q == PW'(PERIOD_CYC - 1)); // RULE_15
   wire scanWin = ~scanOff & (scanCnt_q < PW'(ON_CYC)); // RULE_01 RULE_06
   wire wakeReq = chargeOvercurrentFlag | dischargeOvercurrentFlag | shortCircuitFlag; // RULE_14
   wire supplyWant = forceOn | manualSel | scanWin | wakeReq; // RULE_07 RULE_04 RULE_06
   wire settled = (settleCnt_q == SW'(SETTLE)); // RULE_02 RULE_05

   // qualified comparator sample; held while unpowered or settling
   wire sampleNow = (supSt_q == OTSP_VALID) & supplyWant; // RULE_16
   wire extFailNow = sampleNow ? syncBus.extBelow : extFail_q; // RULE_03
   wire intHot = syncBus.intHot;
   wire extTrip = extFailNow & ~disExt; // RULE_12
   wire intTrip = intHot & ~disInt; // RULE_11
   wire shutNow = extTrip | intTrip; // RULE_08 RULE_09

   // control write with switch bits frozen during shutdown
   wire [31:0] ctrlWr = (ctrl_q & ~beMask) | (avs_writedata & beMask);
   wire [31:0] swBits = (32'h1 << CTRL_CHG) | (32'h1 << CTRL_DSG);
   wire ctrlBlocked = wrCtrl & shutdown_q & (((ctrlWr ^ ctrl_q) & swBits) != 32'h0);
   wire [31:0] ctrlKeep = shutdown_q ? ((ctrlWr & ~swBits) | (ctrl_q & swBits)) : ctrlWr; // RULE_10
   wire [31:0] ctrlNext = shutNow ? (ctrlKeep & ~swBits) : ctrlKeep;
   wire [31:0] ctrlIdle = shutNow ? (ctrl_q & ~swBits) : ctrl_q; // RULE_08

   wire [ST_W-1:0] events = {ctrlBlocked, shutNow & ~shutdown_q, extTrip, intTrip};
   wire [ST_W-1:0] statClr = wrStat ? avs_writedata[ST_W-1:0] : {ST_W{1'b0}};

   wire [31:0] stateWord = {24'h0, 1'b0, intHot, extFail_q, shutdown_q,
                            supply_q, 1'b0, supSt_q};
   wire [31:0] statWord = {{(32-ST_W){1'b0}}, status_q};
   wire [31:0] maskWord = {{(32-ST_W){1'b0}}, mask_q};
   // unmapped addresses read as zero
   wire [31:0] rdMux = selCtrl ? ctrl_q :
                       selStat ? statWord :
                       selMask ? maskWord :
                       selState ? stateWord : 32'h0;

   // supply state: every rising supply restarts settling
   always_comb begin
      supSt_d = supSt_q;
      case (supSt_q)
         OTSP_OFF: begin
            if (supplyWant) supSt_d = OTSP_SETTLE;
         end
         OTSP_SETTLE: begin
            if (!supplyWant) supSt_d = OTSP_OFF;
            else if (settled) supSt_d = OTSP_VALID; // RULE_02
         end
         OTSP_VALID: begin
            if (!supplyWant) supSt_d = OTSP_OFF;
         end
         default: supSt_d = OTSP_OFF;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         scanCnt_q <= '0;
      end else begin
         scanCnt_q <= periodEnd ? '0 : scanCnt_q + PW'(1); // RULE_15
      end
   end

   // settling count restarts on every supply turn-on
   wire [SW-1:0] settleCnt_d = (supSt_q == OTSP_SETTLE && !settled) ? settleCnt_q + SW'(1) : '0; // RULE_05
   wire [31:0] ctrl_d = wrCtrl ? ctrlNext : ctrlIdle;
   wire [ST_W-1:0] status_d = (status_q & ~statClr) | events; // RULE_08
   wire chg_d = ctrl_q[CTRL_CHG] & ~shutNow; // RULE_08
   wire dsg_d = ctrl_q[CTRL_DSG] & ~shutNow; // RULE_08
   wire irq_d = |(status_q & mask_q);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         supSt_q <= OTSP_OFF;
      end else begin
         supSt_q <= supSt_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         settleCnt_q <= '0;
      end else begin
         settleCnt_q <= settleCnt_d; // RULE_05
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         extFail_q <= 1'b0;
      end else begin
         extFail_q <= extFailNow; // RULE_16
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_q <= CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // registered copy gates switch writes, so a write in the recovery cycle is still refused
   always_ff @(posedge core_clk) begin
      if (srst) begin
         shutdown_q <= 1'b0;
      end else begin
         shutdown_q <= shutNow; // RULE_09
      end
   end

   // sticky flags: a new event wins over a same-cycle clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         status_q <= '0;
      end else begin
         status_q <= status_d; // RULE_08
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         mask_q <= '0;
      end else if (wrMask) begin
         mask_q <= avs_writedata[ST_W-1:0];
      end
   end

   // one wait state: request taken, answered next cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= busReq;
      end
   end

   // own flop keeps the stall output free of gates
   always_ff @(posedge core_clk) begin
      if (srst) begin
         waitReq_q <= 1'b1;
      end else begin
         waitReq_q <= ~busReq;
      end
   end

   // read data captured at the taking edge, shown while the stall is low
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_q <= 32'h0;
      end else if (busReq && avs_read) begin
         rdata_q <= rdMux;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         supply_q <= 1'b0;
      end else begin
         supply_q <= supplyWant; // RULE_01 RULE_07 RULE_14
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         route_q <= 1'b0;
      end else begin
         route_q <= manualSel; // RULE_04
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         chg_q <= 1'b0;
      end else begin
         chg_q <= chg_d; // RULE_08
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         dsg_q <= 1'b0;
      end else begin
         dsg_q <= dsg_d; // RULE_08
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = waitReq_q;
   assign thermistorSupplyOut = supply_q;
   assign thermistorToAnalog = route_q;
   assign analogSelectField = ctrl_q[CTRL_SEL_LO +: 4];
   assign chargeSwitchCtrl = chg_q;
   assign dischargeSwitchCtrl = dsg_q;
   assign irq = irq_q;
endmodule : otsp_core

// >>> rtl/otsp_pkg.sv
// shared constants and types for the over-temperature scan and protection block
package otsp_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int SCAN_ON_MS = 5;
   localparam int SCAN_PERIOD_MS = 640;
   localparam int SETTLE_MS = 1;
   localparam int SCAN_ON_CYC = SCAN_ON_MS * (CLK_HZ / 1000);
   localparam int SCAN_PERIOD_CYC = SCAN_PERIOD_MS * (CLK_HZ / 1000);
   localparam int SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
   localparam int TEMP_DIVIDER = 13;
   // analog select code that routes the thermistor input
   localparam logic [3:0] AMUX_EXT_TEMP = 4'h9;
   // register byte addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_MASK = 4'h8;
   localparam logic [3:0] REG_STATE = 4'hC;
   // control register fields
   localparam int CTRL_SCAN_OFF = 0;
   localparam int CTRL_FORCE = 1;
   localparam int CTRL_DIS_INT = 2;
   localparam int CTRL_DIS_EXT = 3;
   localparam int CTRL_CHG = 4;
   localparam int CTRL_DSG = 5;
   localparam int CTRL_SEL_LO = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // sticky status bits
   localparam int ST_IOT = 0;
   localparam int ST_XOT = 1;
   localparam int ST_SHUT = 2;
   localparam int ST_WBLK = 3;
   localparam int ST_W = 4;
   typedef enum logic [1:0] {
      OTSP_OFF = 2'b00,
      OTSP_SETTLE = 2'b01,
      OTSP_VALID = 2'b10
   } otsp_sup_t;
endpackage : otsp_pkg

// >>> rtl/otsp_sync_if.sv
// carrier for synchronised pin levels between the top and its synchroniser
`timescale 1ns/1ps
interface otsp_sync_if;
   logic extBelow;
   logic intHot;
   modport src (output extBelow, output intHot);
   modport dst (input extBelow, input intHot);
endinterface : otsp_sync_if

// >>> rtl/otsp_pin_sync.sv
// three-stage synchroniser for asynchronous comparator pins
`timescale 1ns/1ps
module otsp_pin_sync (
   input wire logic core_clk, // system clock
   input wire logic srst, // synchronous reset
   input wire logic extBelowPin, // thermistor input below supply/13
   input wire logic intHotPin, // internal over-temp comparator
   otsp_sync_if.src syncOut // qualified levels
);
   logic [2:0] extSh_q;
   logic [2:0] intSh_q;
   logic ext_q;
   logic int_q;
   // stage 0 feeds stage 1 only; change accepted once stages 1 and 2 agree
   always_ff @(posedge core_clk) begin
      if (srst) begin
         extSh_q <= 3'h0;
         intSh_q <= 3'h0;
         ext_q <= 1'b0;
         int_q <= 1'b0;
      end else begin
         extSh_q <= {extSh_q[1:0], extBelowPin};
         intSh_q <= {intSh_q[1:0], intHotPin};
         if (extSh_q[1] == extSh_q[2]) ext_q <= extSh_q[2];
         if (intSh_q[1] == intSh_q[2]) int_q <= intSh_q[2];
      end
   end
   assign syncOut.extBelow = ext_q;
   assign syncOut.intHot = int_q;
endmodule : otsp_pin_sync

// >>> bench/otsp_core_props.sv
// port-level assertions for the scan and protection block
`timescale 1ns/1ps
module otsp_core_props
   import otsp_pkg::*;
#(
   parameter int ON_CYC = 20, // scan on-time
   parameter int SETTLE = 5 // settling delay
) (
   input wire logic core_clk, // clock
   input wire logic srst, // reset
   input wire logic [3:0] avs_address, // address
   input wire logic avs_write, // write
   input wire logic [31:0] avs_writedata, // write data
   input wire logic avs_waitrequest, // stall
   input wire logic extBelowPin, // divider low
   input wire logic intHotPin, // die hot
   input wire logic thermistorSupplyOut, // supply
   input wire logic thermistorToAnalog, // routing
   input wire logic [3:0] analogSelectField, // select
   input wire logic chargeSwitchCtrl, // switch
   input wire logic dischargeSwitchCtrl // switch
);
   logic [31:0] ctrl_q;
   int onCount_q;
   int bothCount_q;
   wire ctrlWr = avs_write && !avs_waitrequest && avs_address == REG_CTRL;
   wire selExt = analogSelectField == AMUX_EXT_TEMP;
   wire bothOff = !chargeSwitchCtrl && !dischargeSwitchCtrl;
   // shadow of the control word: the ports alone do not show which responses are enabled
   always_ff @(posedge core_clk) begin
      if (srst || ctrlWr) ctrl_q <= srst ? '0 : avs_writedata;
      onCount_q <= thermistorSupplyOut ? onCount_q + 1 : 0;
      bothCount_q <= (thermistorSupplyOut && extBelowPin) ? bothCount_q + 1 : 0;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence s_hot; intHotPin [*8]; endsequence
   sequence s_wreq; avs_write && avs_waitrequest; endsequence
   property p_req; s_wreq |=> !avs_waitrequest; endproperty
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   property p_route; $stable(analogSelectField) |-> thermistorToAnalog == selExt; endproperty
   property p_sel; selExt [*3] |-> thermistorSupplyOut; endproperty
   property p_force; ctrl_q[CTRL_FORCE] [*3] |-> thermistorSupplyOut; endproperty
   property p_scan; (!ctrl_q[CTRL_FORCE] && !selExt) [*4] |-> onCount_q <= ON_CYC + 1; endproperty
   property p_int; s_hot ##0 !ctrl_q[CTRL_DIS_INT] |-> bothOff; endproperty
   property p_ext; bothCount_q > SETTLE + 10 && !ctrl_q[CTRL_DIS_EXT] |-> bothOff; endproperty
   a_req: assert property (p_req) else $error("write not answered");
   a_one: assert property (p_one) else $error("answer too long");
   a_route: assert property (p_route) else $error("analog routing wrong");
   a_sel: assert property (p_sel) else $error("supply off while selected");
   a_force: assert property (p_force) else $error("supply off while forced");
   a_scan: assert property (p_scan) else $error("scan pulse too long");
   a_int: assert property (p_int) else $error("no internal shutdown");
   a_ext: assert property (p_ext) else $error("no external shutdown");
endmodule : otsp_core_props
bind otsp_core otsp_core_props #(.ON_CYC(ON_CYC), .SETTLE(SETTLE)) u_otsp_core_props (.core_clk, .srst, .avs_address,
   .avs_write, .avs_writedata, .avs_waitrequest, .extBelowPin, .intHotPin, .thermistorSupplyOut, .thermistorToAnalog,
   .analogSelectField, .chargeSwitchCtrl, .dischargeSwitchCtrl);

// >>> bench/otsp_thermistor_model.sv
// thermistor divider: input falls under supply/13 when hot
`timescale 1ns/1ps
module otsp_thermistor_model (
   input wire logic core_clk, // clock
   input wire logic supply, // divider supply
   input wire logic hot, // past the limit
   output logic below // input under reference
);
   logic prev_q = 1'b0;
   always_ff @(posedge core_clk) prev_q <= below;
   // unpowered divider has no valid level; toggle so a stale compare shows up
   assign below = supply ? hot : ~prev_q;
endmodule : otsp_thermistor_model

// >>> bench/otsp_core_bench.sv
// self-checking bench for the scan and protection block
`timescale 1ns/1ps
module otsp_core_bench;
   import otsp_pkg::*;
   localparam int PER = 200;
   localparam int ON = 20;
   localparam int SET = 5;
   logic core_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, intHot = 1'b0, hot = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdq;
   logic [2:0] flags = 3'h0;
   logic avs_waitrequest, extBelow, supply, toAnalog, chg, dsg, irq;
   logic [3:0] sel;
   int errors = 0;
   int comparisons = 0;
   always #10 core_clk = ~core_clk;
   otsp_core #(.PERIOD_CYC(PER), .ON_CYC(ON), .SETTLE(SET)) u_otsp_core (.core_clk, .srst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .extBelowPin(extBelow),
      .intHotPin(intHot), .chargeOvercurrentFlag(flags[0]), .dischargeOvercurrentFlag(flags[1]),
      .shortCircuitFlag(flags[2]), .thermistorSupplyOut(supply), .thermistorToAnalog(toAnalog),
      .analogSelectField(sel), .chargeSwitchCtrl(chg), .dischargeSwitchCtrl(dsg), .irq);
   otsp_thermistor_model u_otsp_thermistor_model (.core_clk, .supply, .hot, .below(extBelow));
   task automatic stop_test;
      if (errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask : cyc
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 30);
      chk("answer", avs_waitrequest, 1'b0);
      if (avs_waitrequest !== 1'b0) stop_test();
      rdq = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask : bus
   task automatic cnt(input string nm, input int exp);
      int c = 0;
      repeat (PER) begin
         @(posedge core_clk);
         c += int'(supply === 1'b1);
      end
      chk(nm, c, exp);
   endtask : cnt
   task automatic t_regs;
      bus(1'b0, REG_CTRL, 32'h0);
      chk("ctrl reset", rdq, CTRL_RESET);
      bus(1'b1, 4'h2, 32'hFFFF_FFFF);
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped", rdq, 32'h0);
   endtask : t_regs
   task automatic t_scan;
      cnt("scan on-time", ON);
      bus(1'b1, REG_CTRL, 32'h1);
      cyc(ON + 4);
      cnt("scan stopped", 0);
      bus(1'b1, REG_CTRL, 32'h3);
      cyc(3);
      cnt("forced on-time", PER);
      bus(1'b0, REG_STATE, 32'h0);
      chk("state forced", rdq, 32'hA);
      bus(1'b1, REG_CTRL, 32'h1);
   endtask : t_scan
   task automatic t_flag;
      for (int i = 0; i < 3; i++) begin
         flags <= 3'h1 << i;
         cyc(3);
         chk("fault supply", supply, 1'b1);
         flags <= 3'h0;
         cyc(3);
         chk("idle supply", supply, 1'b0);
      end
   endtask : t_flag
   task automatic t_man;
      hot <= 1'b1;
      bus(1'b1, REG_CTRL, 32'h0931);
      cyc(1);
      chk("select supply", supply, 1'b1);
      chk("analog route", toAnalog, 1'b1);
      chk("select field", sel, AMUX_EXT_TEMP);
      chk("unsettled", chg, 1'b1);
      cyc(SET + 12);
      chk("settled trip", chg, 1'b0);
      hot <= 1'b0;
      cyc(SET + 12);
      bus(1'b1, REG_STATUS, 32'hF);
      bus(1'b1, REG_CTRL, 32'h1);
   endtask : t_man
   task automatic t_ext;
      bus(1'b1, REG_CTRL, 32'h30);
      bus(1'b1, REG_MASK, 32'h2);
      bus(1'b0, REG_MASK, 32'h0);
      chk("mask", rdq, 32'h2);
      chk("charge on", chg, 1'b1);
      hot <= 1'b1;
      cyc(2 * PER);
      chk("charge off", chg, 1'b0);
      chk("discharge off", dsg, 1'b0);
      chk("irq raised", irq, 1'b1);
      bus(1'b1, REG_CTRL, 32'h30);
      bus(1'b0, REG_STATUS, 32'h0);
      chk("status", rdq, 32'hE);
      chk("write ignored", chg, 1'b0);
      hot <= 1'b0;
      cyc(2 * PER);
      chk("held off", chg, 1'b0);
      bus(1'b1, REG_MASK, 32'h0);
      cyc(2);
      chk("irq masked", irq, 1'b0);
      bus(1'b1, REG_STATUS, 32'hF);
      bus(1'b0, REG_STATUS, 32'h0);
      chk("status cleared", rdq, 32'h0);
      bus(1'b1, REG_CTRL, 32'h30);
      cyc(2);
      chk("recovered", chg, 1'b1);
   endtask : t_ext
   task automatic t_dis;
      bus(1'b1, REG_CTRL, 32'h3C);
      hot <= 1'b1;
      intHot <= 1'b1;
      cyc(2 * PER);
      chk("charge kept", chg, 1'b1);
      chk("discharge kept", dsg, 1'b1);
      hot <= 1'b0;
      intHot <= 1'b0;
      cyc(2 * PER);
      bus(1'b1, REG_CTRL, 32'h30);
      bus(1'b1, REG_STATUS, 32'hF);
      intHot <= 1'b1;
      cyc(12);
      chk("internal trip", dsg, 1'b0);
      bus(1'b0, REG_STATUS, 32'h0);
      chk("internal flag", rdq, 32'h5);
      intHot <= 1'b0;
   endtask : t_dis
   initial begin
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      t_regs();
      t_scan();
      t_flag();
      t_man();
      t_ext();
      t_dis();
      stop_test();
   end
endmodule : otsp_core_bench
